// >>> verilog/ldc_pkg.sv
// What this block does
// RULE1 - capture both lanes on both clock edges
// RULE2 - cd lane bit 15 is msb by default
// RULE3 - bus reverse flips bit order per lane
// RULE4 - strobe can align fifo write pointer
// RULE5 - strobe can feed downstream sync source
// RULE6 - strobe can act as ab lane parity
// RULE7 - strobe sampled on rising edge only
// RULE8 - source drives strobe edge aligned with data
// RULE9 - interface reverse swaps strobe and parity roles; the code swaps the ab and cd lanes and takes mirror_strobe in place of strobe
// RULE10 - ab lane bit 15 is msb by default
// RULE11 - parity mismatch sets sticky error flag
package ldc_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int LANE_W = 16;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_PERIOD_PS = 4000;
  localparam int LINK_PERIOD_PS = 64000;
  // sample a quarter link period after the detected edge, mid-eye of each half
  localparam int SAMPLE_DLY_PS = LINK_PERIOD_PS / 4;
  localparam int SAMPLE_DLY_CYC = (SAMPLE_DLY_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  // link counted idle after two link periods with no edge
  localparam int IDLE_TIME_PS = 2 * LINK_PERIOD_PS;
  localparam int IDLE_CYC = IDLE_TIME_PS / SYS_PERIOD_PS;
  localparam int CNT_W = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_BIT = 1'h0;
  localparam logic [CNT_W-1:0] RST_CNT = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef logic [LANE_W-1:0] ldc_lane_t;

  typedef struct packed {
    logic rev_interface;
    logic rev_bus;
    logic parity_ena;
    logic parity_odd;
    logic align_ena;
    logic sync_ena;
  } ldc_cfg_s;

  typedef struct packed {
    logic link_clk;
    ldc_lane_t ab;
    ldc_lane_t cd;
    logic strobe;
    logic mirror_strobe;
  } ldc_pins_s;

  typedef struct packed {
    ldc_lane_t ab_rise;
    ldc_lane_t cd_rise;
    ldc_lane_t ab_fall;
    ldc_lane_t cd_fall;
    logic strobe;
  } ldc_word_s;

  typedef enum logic [1:0] {
    ST_WAIT_EDGE = 2'b00,
    ST_DELAY = 2'b01,
    ST_CAPTURE = 2'b10
  } ldc_state_e;

endpackage : ldc_pkg

// >>> verilog/ldc_fifo.sv
`timescale 1ns/10ps
module ldc_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic align_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign wr_ready_out = ~full;
  assign rd_valid_out = ~empty;
  assign rd_data_out = mem_q[rd_ptr_q[AW-1:0]];
  assign do_wr = wr_valid_in & ~full;
  assign do_rd = rd_ready_in & ~empty;

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
    end
  end

  // ****************************************
  // pointers
  // ****************************************
  // align drops stored words and puts both pointers at slot zero
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || align_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : ldc_fifo

// >>> verilog/ldc_capture.sv
`timescale 1ns/10ps
module ldc_capture #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic forwarded_data_clock_in,
  input wire logic [ldc_pkg::LANE_W-1:0] ab_lane_data_in,
  input wire logic [ldc_pkg::LANE_W-1:0] cd_lane_data_in,
  input wire logic input_strobe_in,
  input wire logic mirror_strobe_in,
  input wire ldc_pkg::ldc_cfg_s cfg_in,
  input wire logic parity_err_clr_in,
  input wire logic overflow_clr_in,
  input wire logic word_ready_in,
  output logic word_valid_out,
  output ldc_pkg::ldc_word_s word_out,
  output logic sync_pulse_out,
  output logic align_pulse_out,
  output logic parity_err_out,
  output logic overflow_out,
  output logic link_active_out
);

  localparam int PIN_W = $bits(ldc_pkg::ldc_pins_s);
  localparam int WORD_W = $bits(ldc_pkg::ldc_word_s);
  localparam logic [ldc_pkg::CNT_W-1:0] DLY_LOAD = ldc_pkg::CNT_W'(ldc_pkg::SAMPLE_DLY_CYC - 1);
  localparam logic [ldc_pkg::CNT_W-1:0] IDLE_LOAD = ldc_pkg::CNT_W'(ldc_pkg::IDLE_CYC - 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  ldc_pkg::ldc_pins_s pins_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  ldc_pkg::ldc_pins_s pins;

  assign pins_raw.link_clk = forwarded_data_clock_in;
  assign pins_raw.ab = ab_lane_data_in;
  assign pins_raw.cd = cd_lane_data_in;
  assign pins_raw.strobe = input_strobe_in;
  assign pins_raw.mirror_strobe = mirror_strobe_in;

  // everything from the link is asynchronous to clk_sys_in
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pins_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign pins = ldc_pkg::ldc_pins_s'(pin_s2_q);

  // ****************************************
  // link clock edges
  // ****************************************
  logic clk_prev_q;
  logic edge_rise;
  logic edge_fall;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      clk_prev_q <= ldc_pkg::RST_BIT;
    end else begin
      clk_prev_q <= pins.link_clk;
    end
  end

  assign edge_rise = pins.link_clk & ~clk_prev_q;
  assign edge_fall = ~pins.link_clk & clk_prev_q;

  // ****************************************
  // lane and strobe mapping
  // ****************************************
  ldc_pkg::ldc_lane_t ab_sel;
  ldc_pkg::ldc_lane_t cd_sel;
  ldc_pkg::ldc_lane_t ab_rev;
  ldc_pkg::ldc_lane_t cd_rev;
  ldc_pkg::ldc_lane_t ab_map;
  ldc_pkg::ldc_lane_t cd_map;
  logic flip_bits;
  logic strobe_map;

  // a mirrored interface swaps the lanes and inverts rev_bus, so each lane is reversed unless rev_bus is also set
  assign ab_sel = cfg_in.rev_interface ? pins.cd : pins.ab; // [RULE9]
  assign cd_sel = cfg_in.rev_interface ? pins.ab : pins.cd; // [RULE9]
  assign strobe_map = cfg_in.rev_interface ? pins.mirror_strobe : pins.strobe; // [RULE9]
  assign flip_bits = cfg_in.rev_bus ^ cfg_in.rev_interface; // [RULE3]

  for (genvar i = 0; i < ldc_pkg::LANE_W; i++) begin : g_rev
    assign ab_rev[i] = ab_sel[ldc_pkg::LANE_W-1-i]; // [RULE3]
    assign cd_rev[i] = cd_sel[ldc_pkg::LANE_W-1-i]; // [RULE3]
  end

  // default order keeps pin bit 15 as sample msb
  assign ab_map = flip_bits ? ab_rev : ab_sel; // [RULE10] [RULE3]
  assign cd_map = flip_bits ? cd_rev : cd_sel; // [RULE2] [RULE3]

  // ****************************************
  // capture sequencer
  // ****************************************
  ldc_pkg::ldc_state_e state_q;
  ldc_pkg::ldc_state_e state_d;
  logic [ldc_pkg::CNT_W-1:0] dly_q;
  logic rise_pend_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ldc_pkg::ST_WAIT_EDGE: begin
        if (edge_rise || edge_fall) begin
          state_d = (DLY_LOAD == '0) ? ldc_pkg::ST_CAPTURE : ldc_pkg::ST_DELAY;
        end
      end
      ldc_pkg::ST_DELAY: begin
        if (dly_q == 8'h01) begin
          state_d = ldc_pkg::ST_CAPTURE;
        end
      end
      ldc_pkg::ST_CAPTURE: begin
        state_d = ldc_pkg::ST_WAIT_EDGE;
      end
      default: begin
        state_d = ldc_pkg::ST_WAIT_EDGE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_q <= ldc_pkg::ST_WAIT_EDGE;
    end else begin
      state_q <= state_d;
    end
  end

  // edge kind and eye delay, both latched at the detected edge
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      dly_q <= ldc_pkg::RST_CNT;
      rise_pend_q <= ldc_pkg::RST_BIT;
    end else if (state_q == ldc_pkg::ST_WAIT_EDGE && (edge_rise || edge_fall)) begin
      dly_q <= DLY_LOAD;
      rise_pend_q <= edge_rise;
    end else if (dly_q != '0) begin
      dly_q <= dly_q - 1'b1;
    end
  end

  logic cap_rise;
  logic cap_fall;

  assign cap_rise = (state_q == ldc_pkg::ST_CAPTURE) && rise_pend_q; // [RULE1]
  assign cap_fall = (state_q == ldc_pkg::ST_CAPTURE) && !rise_pend_q; // [RULE1]

  // ****************************************
  // rising half and strobe
  // ****************************************
  ldc_pkg::ldc_lane_t ab_rise_q;
  ldc_pkg::ldc_lane_t cd_rise_q;
  logic strobe_q;
  logic have_rise_q;
  logic strobe_up;
  logic parity_bad;

  // strobe is looked at on rising-edge captures only
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ab_rise_q <= '0;
      cd_rise_q <= '0;
      strobe_q <= ldc_pkg::RST_BIT;
    end else if (cap_rise) begin
      ab_rise_q <= ab_map; // [RULE1]
      cd_rise_q <= cd_map; // [RULE1]
      strobe_q <= strobe_map; // [RULE7]
    end
  end

  // a falling capture without a rising one before it is dropped
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || !link_active_out) begin
      have_rise_q <= ldc_pkg::RST_BIT;
    end else if (cap_rise) begin
      have_rise_q <= 1'b1;
    end else if (cap_fall) begin
      have_rise_q <= 1'b0;
    end
  end

  assign parity_bad = cap_rise && cfg_in.parity_ena
                      && ((^ab_map) ^ strobe_map ^ cfg_in.parity_odd); // [RULE6]

  // in parity mode the strobe carries no alignment or sync meaning
  assign strobe_up = cap_rise && strobe_map && !strobe_q && !cfg_in.parity_ena;

  // ****************************************
  // strobe functions
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      align_pulse_out <= ldc_pkg::RST_BIT;
      sync_pulse_out <= ldc_pkg::RST_BIT;
    end else begin
      align_pulse_out <= strobe_up && cfg_in.align_ena; // [RULE4]
      sync_pulse_out <= strobe_up && cfg_in.sync_ena; // [RULE5]
    end
  end

  // set wins over clear
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      parity_err_out <= ldc_pkg::RST_BIT;
    end else if (parity_bad) begin
      parity_err_out <= 1'b1; // [RULE11]
    end else if (parity_err_clr_in) begin
      parity_err_out <= 1'b0;
    end
  end

  // ****************************************
  // word assembly
  // ****************************************
  logic push_q;
  ldc_pkg::ldc_word_s push_word_q;
  logic fifo_wr_ready;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      push_q <= ldc_pkg::RST_BIT;
      push_word_q <= '0;
    end else begin
      push_q <= cap_fall && have_rise_q;
      if (cap_fall) begin
        push_word_q.ab_rise <= ab_rise_q;
        push_word_q.cd_rise <= cd_rise_q;
        push_word_q.ab_fall <= ab_map; // [RULE1]
        push_word_q.cd_fall <= cd_map; // [RULE1]
        push_word_q.strobe <= strobe_q;
      end
    end
  end

  // the link cannot be stalled, so a full fifo loses the word; sticky flag
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      overflow_out <= ldc_pkg::RST_BIT;
    end else if (push_q && !fifo_wr_ready) begin
      overflow_out <= 1'b1;
    end else if (overflow_clr_in) begin
      overflow_out <= 1'b0;
    end
  end

  // ****************************************
  // input fifo
  // ****************************************
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [WORD_W-1:0] fifo_rd_data;

  ldc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .align_in(align_pulse_out), // [RULE4]
    .wr_valid_in(push_q),
    .wr_ready_out(fifo_wr_ready),
    .wr_data_in(push_word_q),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(fifo_rd_ready),
    .rd_data_out(fifo_rd_data)
  );

  // ****************************************
  // output register
  // ****************************************
  assign fifo_rd_ready = !word_valid_out || word_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      word_valid_out <= ldc_pkg::RST_BIT;
      word_out <= '0;
    end else if (fifo_rd_ready) begin
      word_valid_out <= fifo_rd_valid;
      if (fifo_rd_valid) begin
        word_out <= ldc_pkg::ldc_word_s'(fifo_rd_data);
      end
    end
  end

  // ****************************************
  // link activity
  // ****************************************
  logic [ldc_pkg::CNT_W-1:0] idle_q;

  // a stopped forwarded clock must not leave half a pair waiting
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      idle_q <= ldc_pkg::RST_CNT;
      link_active_out <= ldc_pkg::RST_BIT;
    end else if (edge_rise || edge_fall) begin
      idle_q <= IDLE_LOAD;
      link_active_out <= 1'b1;
    end else if (idle_q != '0) begin
      idle_q <= idle_q - 1'b1;
    end else begin
      link_active_out <= 1'b0;
    end
  end

endmodule : ldc_capture

// >>> verification/ldc_capture_asserts.sv
`timescale 1ns/10ps
module ldc_capture_asserts (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic forwarded_data_clock_in,
  input wire ldc_pkg::ldc_cfg_s cfg_in,
  input wire logic parity_err_clr_in,
  input wire logic overflow_clr_in,
  input wire logic word_ready_in,
  input wire logic word_valid_out,
  input wire ldc_pkg::ldc_word_s word_out,
  input wire logic sync_pulse_out,
  input wire logic align_pulse_out,
  input wire logic parity_err_out,
  input wire logic overflow_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // ****************************************
  // properties
  // ****************************************
  property p_hold;
    word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved while stalled");
  property p_ovf_sticky;
    overflow_out && !overflow_clr_in |=> overflow_out;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");
  property p_perr_sticky;
    parity_err_out && !parity_err_clr_in |=> parity_err_out;
  endproperty
  a_perr_sticky: assert property (p_perr_sticky) else $error("parity error lost");
  property p_perr_ena;
    $rose(parity_err_out) |-> cfg_in.parity_ena;
  endproperty
  a_perr_ena: assert property (p_perr_ena) else $error("parity error while off");
  property p_sync_one;
    sync_pulse_out |=> !sync_pulse_out [*2];
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
  property p_sync_ena;
    sync_pulse_out |-> cfg_in.sync_ena && !cfg_in.parity_ena;
  endproperty
  a_sync_ena: assert property (p_sync_ena) else $error("sync pulse while off");
  property p_align_ena;
    align_pulse_out |-> cfg_in.align_ena && !cfg_in.parity_ena;
  endproperty
  a_align_ena: assert property (p_align_ena) else $error("align pulse while off");
  // strobe only taken in the high half of the link clock
  property p_sync_rise;
    sync_pulse_out |-> $past(forwarded_data_clock_in, 5);
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync not from rise");
endmodule : ldc_capture_asserts

bind ldc_capture ldc_capture_asserts ldc_capture_asserts_i (.clk_sys_in, .resetn_in,
  .forwarded_data_clock_in, .cfg_in, .parity_err_clr_in, .overflow_clr_in, .word_ready_in,
  .word_valid_out, .word_out, .sync_pulse_out, .align_pulse_out, .parity_err_out,
  .overflow_out);

// >>> verification/ldc_src_model.sv
`timescale 1ns/10ps
module ldc_src_model (
  input wire logic clk_sys_in,
  output logic link_clk_out,
  output ldc_pkg::ldc_lane_t ab_out,
  output ldc_pkg::ldc_lane_t cd_out,
  output logic strobe_out,
  output logic mirror_out
);
  // link clock stands low between pairs
  initial begin
    link_clk_out = 1'b0;
    ab_out = 16'h0000;
    cd_out = 16'h0000;
    strobe_out = 1'b0;
    mirror_out = 1'b1;
  end
  task automatic send_pair(input ldc_pkg::ldc_lane_t ar, input ldc_pkg::ldc_lane_t cr,
    input ldc_pkg::ldc_lane_t af, input ldc_pkg::ldc_lane_t cf, input logic sr,
    input logic sf);
    @(negedge clk_sys_in);
    link_clk_out = 1'b1;
    ab_out = ar;
    cd_out = cr;
    strobe_out = sr;
    mirror_out = !sr;
    repeat (8) @(negedge clk_sys_in);
    link_clk_out = 1'b0;
    ab_out = af;
    cd_out = cf;
    strobe_out = sf;
    mirror_out = !sf;
    repeat (8) @(negedge clk_sys_in);
    // released lines show the inverse, never a stale copy
    ab_out = ~af;
    cd_out = ~cf;
    strobe_out = !sf;
    mirror_out = sf;
  endtask : send_pair
endmodule : ldc_src_model

// >>> verification/ldc_capture_tb.sv
`timescale 1ns/10ps
module ldc_capture_tb;
  localparam ldc_pkg::ldc_lane_t PA = 16'h8003;
  localparam ldc_pkg::ldc_lane_t PC = 16'h4005;
  localparam ldc_pkg::ldc_lane_t PF = 16'h0A30;
  localparam ldc_pkg::ldc_lane_t PG = 16'h1234;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic lclk, strb, mirr, vld, sync_p, align_p, perr, ovf, act;
  ldc_pkg::ldc_lane_t ab, cd;
  ldc_pkg::ldc_cfg_s cfg = 6'h00;
  logic perr_clr = 1'b0;
  logic ovf_clr = 1'b0;
  logic rdy = 1'b1;
  ldc_pkg::ldc_word_s word;
  ldc_pkg::ldc_word_s got[$];
  int n_fail = 0;
  int num_checks = 0;
  int n_sync = 0;
  int n_align = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  ldc_src_model ldc_src_model_i (.clk_sys_in(clk_sys_in), .link_clk_out(lclk), .ab_out(ab),
    .cd_out(cd), .strobe_out(strb), .mirror_out(mirr));
  ldc_capture ldc_capture_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .forwarded_data_clock_in(lclk), .ab_lane_data_in(ab), .cd_lane_data_in(cd),
    .input_strobe_in(strb), .mirror_strobe_in(mirr), .cfg_in(cfg),
    .parity_err_clr_in(perr_clr), .overflow_clr_in(ovf_clr), .word_ready_in(rdy),
    .word_valid_out(vld), .word_out(word), .sync_pulse_out(sync_p),
    .align_pulse_out(align_p), .parity_err_out(perr), .overflow_out(ovf),
    .link_active_out(act));

  always @(posedge clk_sys_in) begin
    if (vld === 1'b1 && rdy) got.push_back(word);
    if (sync_p === 1'b1) n_sync++;
    if (align_p === 1'b1) n_align++;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [64:0] act, input logic [64:0] exp, input string what);
    num_checks++;
    if (act !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, act, exp);
    end
  endtask : chk
  function automatic ldc_pkg::ldc_lane_t rv(input ldc_pkg::ldc_lane_t v);
    ldc_pkg::ldc_lane_t r;
    for (int i = 0; i < 16; i++) r[i] = v[15-i];
    return r;
  endfunction : rv
  task automatic pw(input ldc_pkg::ldc_lane_t a, input logic sr, input logic sf);
    ldc_src_model_i.send_pair(a, PC, PF, PG, sr, sf);
    repeat (24) @(negedge clk_sys_in);
  endtask : pw
  task automatic pair_chk(input logic sr, input logic sf, input ldc_pkg::ldc_word_s exp,
    input string what);
    got.delete();
    ldc_src_model_i.send_pair(PA, PC, PF, PG, sr, sf);
    for (int i = 0; i < 40 && got.size() == 0; i++) @(negedge clk_sys_in);
    chk(got.size() > 0 ? got.pop_front() : {65{1'bx}}, exp, what);
  endtask : pair_chk
  task automatic pulse_clr(ref logic clr);
    clr = 1'b1;
    @(negedge clk_sys_in);
    clr = 1'b0;
    @(negedge clk_sys_in);
  endtask : pulse_clr

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_order;
    pair_chk(1'b0, 1'b0, {PA, PC, PF, PG, 1'b0}, "order");
    chk(act, 1'b1, "link active");
    // idle timeout is two link periods, so 40 quiet cycles must clear it
    repeat (40) @(negedge clk_sys_in);
    chk(act, 1'b0, "link idle");
    $display("test order done");
  endtask : t_order
  task automatic t_rev;
    cfg.rev_bus = 1'b1;
    pair_chk(1'b0, 1'b0, {rv(PA), rv(PC), rv(PF), rv(PG), 1'b0}, "rev bus");
    cfg = 6'h20;
    pair_chk(1'b0, 1'b0, {rv(PC), rv(PA), rv(PG), rv(PF), 1'b1}, "rev if");
    cfg.rev_bus = 1'b1;
    pair_chk(1'b0, 1'b0, {PC, PA, PG, PF, 1'b1}, "both rev");
    $display("test reverse done");
  endtask : t_rev
  task automatic t_strobe;
    cfg = 6'h03;
    n_sync = 0;
    n_align = 0;
    pair_chk(1'b0, 1'b1, {PA, PC, PF, PG, 1'b0}, "fall strobe");
    chk(n_sync + n_align, 0, "no pulse on fall");
    // stall output: first word parks in the output register, second in the fifo
    rdy = 1'b0;
    got.delete();
    pw(16'h0001, 1'b0, 1'b0);
    pw(16'h0002, 1'b0, 1'b0);
    pw(PA, 1'b1, 1'b1);
    chk(n_sync, 1, "sync pulse");
    chk(n_align, 1, "align pulse");
    rdy = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk(got.size(), 2, "align flush count");
    chk(got.size() > 1 ? got[1] : {65{1'bx}}, {PA, PC, PF, PG, 1'b1}, "after align");
    $display("test strobe done");
  endtask : t_strobe
  task automatic t_parity;
    cfg = 6'h08;
    pw(16'h0001, 1'b1, 1'b0);
    chk(perr, 1'b0, "parity good");
    pw(16'h0003, 1'b1, 1'b0);
    chk(perr, 1'b1, "parity bad");
    pw(16'h0001, 1'b1, 1'b0);
    chk(perr, 1'b1, "parity sticky");
    pulse_clr(perr_clr);
    chk(perr, 1'b0, "parity clear");
    cfg.parity_odd = 1'b1;
    pw(16'h0001, 1'b0, 1'b1);
    chk(perr, 1'b0, "odd good");
    pw(16'h0001, 1'b1, 1'b0);
    chk(perr, 1'b1, "odd bad");
    pulse_clr(perr_clr);
    $display("test parity done");
  endtask : t_parity
  task automatic t_fifo;
    cfg = 6'h00;
    rdy = 1'b0;
    got.delete();
    for (int i = 0; i < 24; i++) ldc_src_model_i.send_pair(16'(i), PC, PF, PG, 1'b0, 1'b0);
    repeat (10) @(negedge clk_sys_in);
    chk(ovf, 1'b1, "overflow");
    rdy = 1'b1;
    repeat (40) @(negedge clk_sys_in);
    chk(got.size() >= 16 && got.size() <= 18, 1'b1, "depth");
    chk(got[0], {16'h0000, PC, PF, PG, 1'b0}, "first kept");
    pulse_clr(ovf_clr);
    chk(ovf, 1'b0, "overflow clear");
    $display("test fifo done");
  endtask : t_fifo

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (3) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    t_order;
    t_rev;
    t_strobe;
    t_parity;
    t_fifo;
    finish_test;
  end
  // about 1000 cycles expected, so 10000 is ample
  initial begin
    #40000;
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    finish_test;
  end
endmodule : ldc_capture_tb
